// ===== design/profile_pkg.sv
// constants, register map and types of the axis profile generator
// assumes a 250 MHz aclk and an AXI4-Lite master with 32-bit data
// How it works
// R1: open-loop profile recomputed every 256 us
// R2: open-loop steps delivered to drive each period
// R3: trapezoidal or S-shaped ramp, chosen by configuration
// R4: open-loop final velocity 1 to 2147483647
// R5: open-loop advance velocity/65536 microsteps per period
// R6: acceleration 1 to 2147483647, 32-bit word assumed
// R7: trapezoid velocity changes by acceleration each period
// R8: ramp distance velocity squared over 131072 acceleration
// R9: closed loop computes control from actual position; code only reports follow_err, steps ignore the encoder
// R10: encoder counts both edges of both channels
// R11: servo period 204.8 us plus n times 51.2
// R12: integer period rounded to nearest step, default 256
// R13: closed-loop final velocity 1 to 2147483647
// R14: closed loop advances velocity/65536 increments per sample
// R15: closed-loop acceleration 1 to 2147483647
// R16: position keeps 16 fractional bits across periods
// R17: decelerate once remaining distance reaches braking distance
package profile_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ           = 250;
  localparam int PROFILE_PERIOD_NS = 256000;
  localparam int SERVO_BASE_NS     = 204800;
  localparam int SERVO_STEP_NS     = 51200;
  localparam int PROFILE_CYCLES    = PROFILE_PERIOD_NS * CLK_MHZ / 1000;
  localparam int SERVO_BASE_CYCLES = SERVO_BASE_NS * CLK_MHZ / 1000;
  localparam int SERVO_STEP_CYCLES = SERVO_STEP_NS * CLK_MHZ / 1000;
  // period index n, and its rounding in tenths of a microsecond
  localparam logic [8:0]  SERVO_N_MAX         = 9'h182;
  localparam logic [8:0]  SERVO_N_DEFAULT     = 9'h001;
  localparam logic [31:0] SERVO_TENTHS_PER_US = 32'h0000000a;
  localparam logic [31:0] SERVO_BASE_TENTHS   = 32'h00000800;
  localparam logic [31:0] SERVO_HALF_STEP     = 32'h00000100;
  localparam int          SERVO_STEP_SHIFT    = 9;
  // ---------------------------------------------------------------
  // arithmetic
  // ---------------------------------------------------------------
  localparam int          FRAC_BITS  = 16;
  localparam int          JERK_SHIFT = 3;
  localparam logic [30:0] LIMIT_MIN  = 31'h00000001;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int         AXI_ADDR_W    = 8;
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_VEL      = 8'h04;
  localparam logic [7:0] ADDR_ACC      = 8'h08;
  localparam logic [7:0] ADDR_TARGET   = 8'h0c;
  localparam logic [7:0] ADDR_SERVO    = 8'h10;
  localparam logic [7:0] ADDR_STATUS   = 8'h14;
  localparam logic [7:0] ADDR_POSITION = 8'h18;
  localparam logic [7:0] ADDR_ENCODER  = 8'h1c;
  localparam logic [7:0] ADDR_CUR_VEL  = 8'h20;
  localparam logic [7:0] ADDR_FOLLOW   = 8'h24;
  localparam int CTRL_GO     = 0;
  localparam int CTRL_CLOSED = 1;
  localparam int CTRL_SCURVE = 2;
  localparam int CTRL_STOP   = 3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    MV_IDLE,
    MV_ACCEL,
    MV_CRUISE,
    MV_DECEL
  } move_state_t;
endpackage

// ===== design/axis_velocity_profile_generator.sv
// per-axis point-to-point profile generator with AXI4-Lite registers
// assumes enc_a/enc_b already synchronous to aclk and filtered
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module axis_velocity_profile_generator #(
  parameter int PROFILE_CYC    = profile_pkg::PROFILE_CYCLES,
  parameter int SERVO_BASE_CYC = profile_pkg::SERVO_BASE_CYCLES,
  parameter int SERVO_STEP_CYC = profile_pkg::SERVO_STEP_CYCLES
) (
  // clock, reset, enable
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  input  wire logic                              ce,
  // axi4-lite write
  input  wire logic [profile_pkg::AXI_ADDR_W-1:0] awaddr,
  input  wire logic                              awvalid,
  output logic                                   awready,
  input  wire logic [31:0]                       wdata,
  input  wire logic [3:0]                        wstrb,
  input  wire logic                              wvalid,
  output logic                                   wready,
  output logic [1:0]                             bresp,
  output logic                                   bvalid,
  input  wire logic                              bready,
  // axi4-lite read
  input  wire logic [profile_pkg::AXI_ADDR_W-1:0] araddr,
  input  wire logic                              arvalid,
  output logic                                   arready,
  output logic [31:0]                            rdata,
  output logic [1:0]                             rresp,
  output logic                                   rvalid,
  input  wire logic                              rready,
  // encoder
  input  wire logic                              enc_a,
  input  wire logic                              enc_b,
  // drive side
  output logic                                   step_strobe,
  output logic                                   step_dir,
  output logic [31:0]                            step_delta,
  output logic [31:0]                            cmd_pos,
  output logic [31:0]                            follow_err
);
  import profile_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (old & ~m) | (d & m);
  endfunction

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic                  aw_full_r;
  logic                  w_full_r;
  logic [AXI_ADDR_W-1:0] waddr_r;
  logic [31:0]           wdata_r;
  logic [3:0]            wstrb_r;
  logic                  wr_fire;
  logic                  wr_hit;
  logic                  go_p;
  logic                  stop_p;
  logic                  rd_hit;
  logic [31:0]           rd_val;
  logic                  closed_r;
  logic                  scurve_r;
  logic [30:0]           vel_max_r;
  logic [30:0]           acc_max_r;
  logic [31:0]           target_r;
  logic [8:0]            servo_n_r;
  logic [8:0]            servo_n_nxt;
  logic [31:0]           tenths;
  logic [31:0]           n_calc;
  logic [31:0]           prof_cnt_r;
  logic [31:0]           servo_cnt_r;
  logic [31:0]           servo_cyc;
  logic                  prof_tick;
  logic                  servo_tick;
  logic                  move_tick;
  move_state_t           state_r;
  move_state_t           st_nxt;
  logic [31:0]           vel_cur_r;
  logic [31:0]           v_nxt;
  logic [31:0]           acc_cur_r;
  logic [31:0]           a_nxt;
  logic signed [47:0]    pos_r;
  logic signed [47:0]    pos_nxt;
  logic signed [31:0]    tgt_r;
  logic                  stop_req_r;
  logic [31:0]           vlim;
  logic [31:0]           alim;
  logic [31:0]           jerk;
  logic [31:0]           step_a;
  logic signed [48:0]    diff;
  logic [48:0]           rem;
  logic [81:0]           brake_lhs;
  logic [63:0]           vsq;
  logic                  brake;
  logic [1:0]            ab_prev_r;
  logic [31:0]           enc_cnt_r;

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  assign wr_fire = aw_full_r & w_full_r & ~bvalid;
  assign wr_hit  = (waddr_r <= ADDR_FOLLOW) && (waddr_r[1:0] == 2'h0);
  assign go_p    = wr_fire && (waddr_r == ADDR_CTRL) && wstrb_r[0]
                   && wdata_r[CTRL_GO];
  assign stop_p  = wr_fire && (waddr_r == ADDR_CTRL) && wstrb_r[0]
                   && wdata_r[CTRL_STOP];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      awready   <= 1'b1;
      wready    <= 1'b1;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      waddr_r   <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_full_r <= 1'b1;
        awready   <= 1'b0;
        waddr_r   <= awaddr;
      end
      if (wvalid && wready) begin
        w_full_r <= 1'b1;
        wready   <= 1'b0;
        wdata_r  <= wdata;
        wstrb_r  <= wstrb;
      end
      if (wr_fire) begin
        aw_full_r <= 1'b0;
        w_full_r  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // servo period rounding
  // ---------------------------------------------------------------
  always_comb begin
    tenths = 32'(wdata_r[15:0]) * SERVO_TENTHS_PER_US;
    n_calc = '0;
    if (tenths > SERVO_BASE_TENTHS) begin
      n_calc = (tenths - SERVO_BASE_TENTHS + SERVO_HALF_STEP)
               >> SERVO_STEP_SHIFT;  // [R12]
    end
    if (n_calc > 32'(SERVO_N_MAX)) begin
      servo_n_nxt = SERVO_N_MAX;  // [R11]
    end else begin
      servo_n_nxt = n_calc[8:0];
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      closed_r  <= 1'b0;
      scurve_r  <= 1'b0;
      vel_max_r <= LIMIT_MIN;
      acc_max_r <= LIMIT_MIN;
      target_r  <= '0;
      servo_n_r <= SERVO_N_DEFAULT;  // [R12]
    end else if (ce && wr_fire) begin
      unique case (waddr_r)
        ADDR_CTRL: begin
          if (wstrb_r[0]) begin
            closed_r <= wdata_r[CTRL_CLOSED];
            scurve_r <= wdata_r[CTRL_SCURVE];  // [R3]
          end
        end
        ADDR_VEL:    vel_max_r <= 31'(merge({1'b0, vel_max_r}, wdata_r,
                                            wstrb_r));
        ADDR_ACC:    acc_max_r <= 31'(merge({1'b0, acc_max_r}, wdata_r,
                                            wstrb_r));
        ADDR_TARGET: target_r  <= merge(target_r, wdata_r, wstrb_r);
        ADDR_SERVO:  servo_n_r <= servo_n_nxt;
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  always_comb begin
    rd_hit = 1'b1;
    unique case (araddr)
      ADDR_CTRL:     rd_val = {28'h0, 1'b0, scurve_r, closed_r, 1'b0};
      ADDR_VEL:      rd_val = {1'b0, vel_max_r};
      ADDR_ACC:      rd_val = {1'b0, acc_max_r};
      ADDR_TARGET:   rd_val = target_r;
      ADDR_SERVO:    rd_val = {23'h0, servo_n_r};
      ADDR_STATUS:   rd_val = {28'h0, state_r, stop_req_r, step_dir};
      ADDR_POSITION: rd_val = cmd_pos;
      ADDR_ENCODER:  rd_val = enc_cnt_r;
      ADDR_CUR_VEL:  rd_val = vel_cur_r;
      ADDR_FOLLOW:   rd_val = follow_err;
      default: begin
        rd_val = '0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_val;
        rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // period ticks
  // ---------------------------------------------------------------
  assign servo_cyc  = 32'(SERVO_BASE_CYC)
                      + {23'h0, servo_n_r} * 32'(SERVO_STEP_CYC);  // [R11]
  assign prof_tick  = (prof_cnt_r == 32'(PROFILE_CYC - 1));  // [R1]
  assign servo_tick = (servo_cnt_r >= servo_cyc - 32'h1);
  assign move_tick  = closed_r ? servo_tick : prof_tick;  // [R2] [R9]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prof_cnt_r  <= '0;
      servo_cnt_r <= '0;
    end else if (ce) begin
      prof_cnt_r  <= prof_tick ? '0 : prof_cnt_r + 32'h1;
      servo_cnt_r <= servo_tick ? '0 : servo_cnt_r + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // profile arithmetic
  // ---------------------------------------------------------------
  // zero is outside the legal range, treat it as the minimum
  assign vlim = {1'b0, (vel_max_r == '0) ? LIMIT_MIN : vel_max_r};  // [R4] [R13]
  assign alim = {1'b0, (acc_max_r == '0) ? LIMIT_MIN : acc_max_r};  // [R6] [R15]
  assign jerk = ((alim >> JERK_SHIFT) == '0) ? 32'h1 : alim >> JERK_SHIFT;
  assign step_a = scurve_r ? acc_cur_r : alim;  // [R3]
  assign diff = 49'($signed({tgt_r, 16'h0})) - 49'(pos_r);
  assign rem  = diff[48] ? 49'(-diff) : 49'(diff);
  // braking distance v^2/(131072*acc) microsteps, in 16-bit fraction
  assign brake_lhs = {32'h0, rem, 1'b0} * {50'h0, alim};  // [R8]
  assign vsq       = {32'h0, vel_cur_r} * {32'h0, vel_cur_r};
  assign brake     = (vel_cur_r != '0) && (brake_lhs <= {18'h0, vsq});  // [R17]

  always_comb begin
    st_nxt  = state_r;
    v_nxt   = vel_cur_r;
    a_nxt   = acc_cur_r;
    pos_nxt = pos_r;
    if (state_r != MV_IDLE) begin
      if (brake || stop_req_r) begin
        st_nxt = MV_DECEL;  // [R17]
        if (vel_cur_r > step_a) begin
          v_nxt = vel_cur_r - step_a;  // [R7]
        end else if (stop_req_r) begin
          v_nxt  = '0;
          st_nxt = MV_IDLE;
        end
      end else if (vel_cur_r < vlim) begin
        st_nxt = MV_ACCEL;
        v_nxt  = (vlim - vel_cur_r > step_a) ? vel_cur_r + step_a
                                             : vlim;  // [R7]
      end else begin
        st_nxt = MV_CRUISE;
        v_nxt  = vlim;
      end
      if (rem <= {17'h0, v_nxt}) begin
        st_nxt  = MV_IDLE;
        v_nxt   = '0;
        pos_nxt = {tgt_r, 16'h0};
      end else if (st_nxt != MV_IDLE) begin
        // fraction carried in pos_r low bits
        pos_nxt = step_dir ? pos_r + 48'(v_nxt)
                           : pos_r - 48'(v_nxt);  // [R5] [R14] [R16]
      end
      if (st_nxt != state_r) begin
        a_nxt = jerk;
      end else if (alim - acc_cur_r > jerk) begin
        a_nxt = acc_cur_r + jerk;
      end else begin
        a_nxt = alim;
      end
    end
  end

  // ---------------------------------------------------------------
  // move sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r   <= MV_IDLE;
      vel_cur_r <= '0;
      acc_cur_r <= '0;
      pos_r     <= '0;
      tgt_r     <= '0;
      step_dir  <= 1'b1;
    end else if (ce) begin
      if (go_p && state_r == MV_IDLE) begin
        state_r   <= MV_ACCEL;
        vel_cur_r <= '0;
        acc_cur_r <= jerk;
        tgt_r     <= target_r;
        step_dir  <= $signed(target_r) >= $signed(pos_r[47:FRAC_BITS]);
      end else if (move_tick) begin
        state_r   <= st_nxt;
        vel_cur_r <= v_nxt;
        acc_cur_r <= a_nxt;
        pos_r     <= pos_nxt;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_req_r <= 1'b0;
    end else if (ce) begin
      if (state_r == MV_IDLE) begin
        stop_req_r <= 1'b0;
      end else if (stop_p) begin
        stop_req_r <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // step delivery
  // ---------------------------------------------------------------
  assign cmd_pos = pos_r[47:FRAC_BITS];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_strobe <= 1'b0;
      step_delta  <= '0;
    end else if (ce) begin
      step_strobe <= 1'b0;
      if (move_tick && state_r != MV_IDLE && !go_p) begin
        step_strobe <= 1'b1;  // [R2]
        // magnitude only, step_dir carries the sign
        step_delta  <= step_dir
                       ? pos_nxt[47:FRAC_BITS] - pos_r[47:FRAC_BITS]
                       : pos_r[47:FRAC_BITS] - pos_nxt[47:FRAC_BITS];
      end
    end
  end

  // ---------------------------------------------------------------
  // quadrature decode and position error
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ab_prev_r <= '0;
      enc_cnt_r <= '0;
    end else if (ce) begin
      ab_prev_r <= {enc_a, enc_b};
      case ({ab_prev_r, enc_a, enc_b})
        4'h1, 4'h7, 4'he, 4'h8: enc_cnt_r <= enc_cnt_r + 32'h1;  // [R10]
        4'h2, 4'hb, 4'hd, 4'h4: enc_cnt_r <= enc_cnt_r - 32'h1;  // [R10]
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      follow_err <= '0;
    end else if (ce && closed_r && servo_tick) begin
      follow_err <= cmd_pos - enc_cnt_r;  // [R9]
    end
  end
endmodule
`default_nettype wire

// ===== test/profile_monitor.sv
// port checker for the axis profile generator
// assumes a bind into the design top, one aclk domain
`timescale 1ns/1ps
`default_nettype none
module profile_monitor #(
  parameter int SERVO_BASE_CYC = 40
) (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic [1:0]  rresp,
  input wire logic [31:0] rdata,
  // drive side
  input wire logic        step_strobe,
  input wire logic [31:0] step_delta,
  input wire logic [31:0] cmd_pos
);
  import profile_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  int gap_r;
  // cycles since the last tick strobe, 0 before the first
  always_ff @(posedge aclk) begin
    if (!aresetn) gap_r <= 0;
    else if (step_strobe) gap_r <= 1;
    else if (gap_r != 0 && gap_r < 100000) gap_r <= gap_r + 1;
  end
  strobe_one_cycle_a: assert property (step_strobe |=> !step_strobe)
    else $error("tick strobe longer than one cycle");
  tick_spacing_a: assert property (
    step_strobe && gap_r != 0 |-> gap_r >= SERVO_BASE_CYC)
    else $error("tick strobes closer than the shortest period");
  delta_bound_a: assert property (
    step_strobe |-> step_delta <= 32'h00008000)
    else $error("step count above the largest velocity");
  pos_at_tick_a: assert property (
    $changed(cmd_pos) |-> (step_strobe || $past(step_strobe)) or
    (##1 step_strobe))
    else $error("position moved away from a tick");
  write_answer_a: assert property (
    awvalid && awready && wvalid && wready |=> !awready && !wready ##1 bvalid)
    else $error("write not answered two cycles after it was taken");
  b_release_a: assert property (
    bvalid && bready |=> !bvalid && awready && wready)
    else $error("write channel not reopened after response");
  read_answer_a: assert property (
    arvalid && arready |=> rvalid && !arready)
    else $error("read not answered one cycle after it was taken");
  slverr_zero_a: assert property (
    rvalid && rresp == RESP_SLVERR |-> rdata == 32'h00000000)
    else $error("refused read returned nonzero data");
endmodule
`default_nettype wire

// ===== test/motor_stage_model.sv
// motor stage and quadrature encoder behind the step outputs
// assumes the stage follows each tick's step count before the next tick
`timescale 1ns/1ps
`default_nettype none
module motor_stage_model #(
  parameter int SLOW = 1
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // step commands
  input  wire logic        step_strobe,
  input  wire logic        step_dir,
  input  wire logic [31:0] step_delta,
  // encoder lines
  output logic             enc_a,
  output logic             enc_b
);
  logic [31:0] pend_r;
  logic        up_r;
  logic [1:0]  ph_r;
  int          wait_r;
  // one encoder edge per microstep, SLOW idle cycles between edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_r <= 32'h00000000;
      up_r <= 1'b1;
      ph_r <= 2'h0;
      wait_r <= 0;
    end else if (step_strobe) begin
      pend_r <= step_delta;
      up_r <= step_dir;
    end else if (pend_r != 32'h00000000) begin
      if (wait_r < SLOW) wait_r <= wait_r + 1;
      else begin
        wait_r <= 0;
        pend_r <= pend_r - 32'h00000001;
        ph_r <= up_r ? ph_r + 2'h1 : ph_r - 2'h1;
      end
    end
  end
  assign enc_a = ph_r[1];
  assign enc_b = ph_r[1] ^ ph_r[0];
endmodule
`default_nettype wire

// ===== test/axis_velocity_profile_generator_tb.sv
// self-checking bench for the axis profile generator
// assumes profile_pkg, the stage model and the monitor compiled first
`timescale 1ns/1ps
`default_nettype none
module axis_velocity_profile_generator_tb;
  import profile_pkg::*;
  localparam int PCYC = 64;
  localparam int SBASE = 40;
  localparam int SSTEP = 10;
  localparam logic [15:0] SUS [5] = '{16'h00cc, 16'h4e20, 16'h4e12,
                                      16'h00e6, 16'h00e7};
  localparam logic [31:0] SN [5] = '{32'h0, 32'h182, 32'h182, 32'h0, 32'h1};
  logic        aclk, aresetn, ce, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic        enc_a, enc_b, step_strobe, step_dir;
  logic [7:0]  awaddr, araddr;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [31:0] wdata, rdata, step_delta, cmd_pos, follow_err;
  logic [31:0] dl [256];
  int          bad_count, samples_checked, nd;
  axis_velocity_profile_generator #(.PROFILE_CYC(PCYC),
    .SERVO_BASE_CYC(SBASE), .SERVO_STEP_CYC(SSTEP)) DUT (
    .aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .enc_a, .enc_b,
    .step_strobe, .step_dir, .step_delta, .cmd_pos, .follow_err);
  motor_stage_model #(.SLOW(1)) stage (.aclk, .aresetn, .step_strobe,
    .step_dir, .step_delta, .enc_a, .enc_b);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic end_of_test;
    if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(nm, d, e);
  endtask
  // program a move, log each tick's step count until it settles
  task automatic move(input logic [31:0] ctl, vel, acc, tgt, input int gap);
    logic [1:0]  r;
    logic [31:0] st, sum;
    int          last;
    st = cmd_pos;
    sum = 32'h0;
    wr(ADDR_VEL, vel, r);
    wr(ADDR_ACC, acc, r);
    wr(ADDR_TARGET, tgt, r);
    wr(ADDR_CTRL, ctl, r);
    nd = 0;
    last = 0;
    for (int c = 0; c < 20000; c++) begin
      // the first strobe may already stand when the go write returns
      if (step_strobe) begin
        if (nd > 0) chk("tick gap", 32'(c - last), 32'(gap));
        if (nd < 256) dl[nd] = step_delta;
        sum = sum + step_delta;
        nd++;
        last = c;
      end
      if (cmd_pos === tgt && c - last > 2 * gap) break;
      @(posedge aclk);
    end
    chk("final position", cmd_pos, tgt);
    chk("step total", sum, $signed(tgt) > $signed(st) ? tgt - st : st - tgt);
    rchk("position reg", ADDR_POSITION, tgt);
    rchk("encoder count", ADDR_ENCODER, tgt);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk("step_delta", step_delta, 32'h0);
    chk("cmd_pos", cmd_pos, 32'h0);
    chk("step_dir", 32'(step_dir), 32'h1);
    rchk("vel reset", ADDR_VEL, 32'h1);
    rchk("acc reset", ADDR_ACC, 32'h1);
    rchk("servo reset", ADDR_SERVO, 32'h1);
    rchk("status reset", ADDR_STATUS, 32'h1);
  endtask
  task automatic t_bus;
    logic [31:0] d;
    logic [1:0]  r;
    rd(8'h28, d, r);
    chk("unmapped rdata", d, 32'h0);
    chk("unmapped rresp", 32'(r), 32'(RESP_SLVERR));
    wr(8'h05, 32'h00000009, r);
    chk("unaligned bresp", 32'(r), 32'(RESP_SLVERR));
    wr(ADDR_STATUS, 32'h0000000f, r);
    chk("read-only bresp", 32'(r), 32'(RESP_OKAY));
    rchk("status kept", ADDR_STATUS, 32'h1);
    rchk("vel kept", ADDR_VEL, 32'h1);
  endtask
  task automatic t_servo;
    logic [1:0] r;
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_SERVO, {16'h0, SUS[i]}, r);
      rchk("servo index", ADDR_SERVO, SN[i]);
    end
  endtask
  task automatic t_trap;
    logic [31:0] s8;
    s8 = 32'h0;
    move(32'h1, 32'h00020000, 32'h00004000, 32'h28, PCYC);
    for (int i = 0; i < 8; i++) s8 = s8 + dl[i];
    chk("ramp distance", s8, 32'h9);
    chk("cruise step", dl[8], 32'h2);
    chk("dir up", 32'(step_dir), 32'h1);
  endtask
  task automatic t_scurve;
    move(32'h5, 32'h00080000, 32'h00080000, 32'h0, PCYC);
    chk("s-curve first step", dl[0], 32'h1);
    chk("dir down", 32'(step_dir), 32'h0);
  endtask
  task automatic t_closed;
    move(32'h3, 32'h00030000, 32'h00030000, 32'h3c, SBASE + SSTEP);
    chk("servo first step", dl[0], 32'h3);
    chk("servo cruise step", dl[1], 32'h3);
    chk("follow error", follow_err, 32'h0);
  endtask
  initial begin
    {ce, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
    {awaddr, araddr, wstrb, wdata} = '0;
    bad_count = 0;
    samples_checked = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_bus;
    t_servo;
    t_trap;
    t_scurve;
    t_closed;
    end_of_test;
  end
  initial begin
    repeat (60000) @(posedge aclk);
    bad_count++;
    end_of_test;
  end
endmodule
bind axis_velocity_profile_generator profile_monitor #(
  .SERVO_BASE_CYC(SERVO_BASE_CYC)) mon (.aclk, .aresetn, .awvalid,
  .awready, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready,
  .rvalid, .rresp, .rdata, .step_strobe, .step_delta, .cmd_pos);
`default_nettype wire
